/* File: multidev_regs.svh */
/*
 * Register map, field values and timing counts of the multi-chip setup.
 * Assumes a 250 MHz core clock and 8-bit registers on the serial port.
 */
`ifndef MULTIDEV_REGS_SVH
`define MULTIDEV_REGS_SVH
// Operation
// - Master with sync pin as output drives sync pulse to slave sync inputs.
// - Master runs from crystal clock and forwards it on the clock pin.
// - Clock config 0x05: crystal, oscillator to core, clock pin driver on.
// - Clock config 0x06: core runs from external clock on clock pin.
// - Data-ready source 0x08: data-ready follows channel 1 path.
// - Data-ready source 0x00: data-ready pin never asserted.
// - Sync source 0x08: master sync output follows channel 1 path.
// - Sync source 0x40: sync driver off, pin is an input.
// - Loop read-back 0x30 gives channels 1-2, 0x70 gives channels 1-3.
// - Host writes 0x01 to main config; device then starts conversion.
// - Second-stage decimation code 0x02 means ratio 5 for all channels.
// - Third-stage code 0x02 means ratio 6, per channel from 0x22.
// - Channel shutdown 0x24 powers down channel 3 signal path.
// - Master routes: 0x11 is electrode 2 minus 1, 0x19 is 3 minus 1.
// - Slave routes 0x0C, 0x14, 0x1C: electrodes 1, 2, 3 against 4.
// - Common-mode detector 0x07 senses electrodes 1, 2 and 3.
// - Right-leg-drive route 0x04 ties the amplifier to electrode 4.
// - Terminal buffer routes 0x01..0x03 attach buffers to electrodes 1..3.
// - After start all devices convert in step, paced by sync.

// Register offsets
`define ADDR_MAIN_CONFIG 7'h00
`define ADDR_CH1_ROUTE 7'h01
`define ADDR_CH2_ROUTE 7'h02
`define ADDR_CH3_ROUTE 7'h03
`define ADDR_CMD_ENABLE 7'h0A
`define ADDR_LEG_DRIVE_ROUTE 7'h0C
`define ADDR_BUF1_ROUTE 7'h0D
`define ADDR_BUF2_ROUTE 7'h0E
`define ADDR_BUF3_ROUTE 7'h0F
`define ADDR_CLK_CONFIG 7'h12
`define ADDR_CH_SHUTDOWN 7'h14
`define ADDR_STAGE2_DECIM 7'h21
`define ADDR_STAGE3_DECIM1 7'h22
`define ADDR_STAGE3_DECIM3 7'h24
`define ADDR_DRDY_SOURCE 7'h27
`define ADDR_SYNC_SOURCE 7'h28
`define ADDR_LOOP_ENABLE 7'h2F
`define ADDR_STATUS 7'h31
`define ADDR_LOOP_DATA 7'h50
`define REG_SPACE 48
`define REG_RESET 8'h00

// Field positions
`define MAIN_START_BIT 0
`define CLK_PIN_EN_BIT 0
`define CLK_EXT_SEL_BIT 1
`define CLK_XTAL_EN_BIT 2
`define SRC_CH1_BIT 3
`define SYNC_INPUT_BIT 6
`define LOOP_CH1_BIT 4
`define SPI_READ_BIT 7

// Decimation codes and ratios
`define R1_RATIO 8'h04
`define STAGE2_CODE_4 8'h01
`define STAGE2_CODE_5 8'h02
`define STAGE2_CODE_6 8'h04
`define STAGE2_CODE_8 8'h08
`define STAGE3_CODE_4 8'h01
`define STAGE3_CODE_6 8'h02
`define STAGE3_CODE_8 8'h04
`define STAGE3_CODE_12 8'h08

// Timing
`define MCLK_MHZ 250
`define SYNC_PULSE_NS 500
`define SYNC_PULSE_CYC ((`SYNC_PULSE_NS * `MCLK_MHZ + 999) / 1000)
`endif

/* File: multidev_pkg.sv */
/*
 * Types shared by the multi-chip setup block.
 * Assumes the constants of multidev_regs.svh.
 */
package multidev_pkg;
	typedef enum logic {SPI_CMD, SPI_DATA} spi_phase_e;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		byte_t c1;
		byte_t c2;
		byte_t c3;
		logic strobe;
		byte_t count;
	} decim_state_s;
endpackage : multidev_pkg

/* File: pin_sync.sv */
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes inputs are asynchronous to mclk_i.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Levels
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_s;
	sync_state_s st_r;
	sync_state_s st_nxt;

	always_comb begin
		st_nxt.first = async_i;
		st_nxt.second = st_r.first;
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_o = st_r.second;
endmodule : pin_sync

/* File: decim_chain.sv */
/*
 * Three-stage decimation counter of one channel; strobes once per sample.
 * Assumes tick_i is a one-cycle pulse per core clock period.
 */
`timescale 1ns/1ps
`include "multidev_regs.svh"
module decim_chain (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Control
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic realign_i,
	input wire multidev_pkg::byte_t stage2_code_i,
	input wire multidev_pkg::byte_t stage3_code_i,
	// Samples
	output logic strobe_o,
	output multidev_pkg::byte_t count_o
);
	import multidev_pkg::*;
	decim_state_s st_r;
	decim_state_s st_nxt;
	byte_t ratio2;
	byte_t ratio3;

	always_comb begin
		case (stage2_code_i)
			`STAGE2_CODE_4: ratio2 = 8'h04;
			`STAGE2_CODE_5: ratio2 = 8'h05;
			`STAGE2_CODE_6: ratio2 = 8'h06;
			`STAGE2_CODE_8: ratio2 = 8'h08;
			default: ratio2 = 8'h04;
		endcase
		case (stage3_code_i)
			`STAGE3_CODE_4: ratio3 = 8'h04;
			`STAGE3_CODE_6: ratio3 = 8'h06;
			`STAGE3_CODE_8: ratio3 = 8'h08;
			`STAGE3_CODE_12: ratio3 = 8'h0C;
			default: ratio3 = 8'h04;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.strobe = 1'b0;
		if (!run_i || realign_i) begin
			st_nxt.c1 = 8'h00;
			st_nxt.c2 = 8'h00;
			st_nxt.c3 = 8'h00;
		end else if (tick_i) begin
			st_nxt.c1 = st_r.c1 + 8'h01;
			if (st_r.c1 >= `R1_RATIO - 8'h01) begin
				st_nxt.c1 = 8'h00;
				st_nxt.c2 = st_r.c2 + 8'h01;
				if (st_r.c2 >= ratio2 - 8'h01) begin
					st_nxt.c2 = 8'h00;
					st_nxt.c3 = st_r.c3 + 8'h01;
					if (st_r.c3 >= ratio3 - 8'h01) begin
						st_nxt.c3 = 8'h00;
						st_nxt.strobe = 1'b1;
						st_nxt.count = st_r.count + 8'h01;
					end
				end
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign strobe_o = st_r.strobe;
	assign count_o = st_r.count;
endmodule : decim_chain

/* File: multidev_sync.sv */
/*
 * Front-end digital core for multi-chip setups: serial register port,
 * clock sourcing and forwarding, sync pulse out or in, data-ready pin,
 * per-channel decimation, analog routing fields and loop read-back.
 * Assumes serial port, crystal and peer pins are asynchronous to mclk_i
 * and that the serial clock is well below mclk_i / 4.
 */
`timescale 1ns/1ps
`include "multidev_regs.svh"
module multidev_sync (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Serial register port
	input wire logic chip_select_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_o,
	// Clock sources and shared clock pin
	input wire logic crystal_pin_a_i,
	input wire logic clk_pin_i,
	output logic clk_pin_o,
	output logic clk_pin_oe_o,
	// Shared sync pin
	input wire logic sync_pulse_pin_n_i,
	output logic sync_pulse_pin_n_o,
	output logic sync_pulse_pin_n_oe_o,
	// Data-ready pin
	output logic sample_ready_pin_n_o,
	// Channel routing
	output logic [2:0] ch1_positive_channel_input_o,
	output logic [2:0] ch1_negative_channel_input_o,
	output logic [2:0] ch2_positive_channel_input_o,
	output logic [2:0] ch2_negative_channel_input_o,
	output logic [2:0] ch3_positive_channel_input_o,
	output logic [2:0] ch3_negative_channel_input_o,
	// Analog support routing
	output logic [2:0] cmd_enable_o,
	output logic [3:0] right_leg_drive_route_o,
	output logic [2:0] buf1_route_o,
	output logic [2:0] buf2_route_o,
	output logic [2:0] buf3_route_o,
	output logic [2:0] channel_power_o
);
	import multidev_pkg::*;

	typedef struct packed {
		logic [`REG_SPACE-1:0][7:0] regs;
		spi_phase_e phase;
		logic rd;
		logic [6:0] addr;
		byte_t shin;
		logic [2:0] bitc;
		byte_t shout;
		logic sclk_q;
		logic cs_q;
		logic clk_q;
		logic sync_q;
		logic tick;
		logic realign;
		logic [1:0] loop_ch;
		byte_t sync_cnt;
		logic sdo;
		logic sdo_oe;
		logic drdy_n;
		logic sync_out_n;
		logic sync_oe;
		logic clk_out;
		logic clk_oe;
		logic [2:0] power;
	} top_state_s;

	top_state_s st_r;
	top_state_s st_nxt;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [5:0] pins;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic xtal;
	logic clk_in;
	logic sync_in_n;

	pin_sync #(.WIDTH(6)) u_pins (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.async_i({chip_select_n_i, sclk_i, sdi_i, crystal_pin_a_i,
			clk_pin_i, sync_pulse_pin_n_i}),
		.sync_o(pins)
	);

	assign cs_n = pins[5];
	assign sclk = pins[4];
	assign sdi = pins[3];
	assign xtal = pins[2];
	assign clk_in = pins[1];
	assign sync_in_n = pins[0];

	// ****************************************
	// Register fields
	// ****************************************
	byte_t clk_cfg;
	byte_t shutdown;
	byte_t drdy_src;
	byte_t sync_src;
	byte_t loop_en;
	logic running;
	logic sync_is_input;
	logic [2:0] ch_on;
	logic [2:0] strobe;
	byte_t count [3];

	assign clk_cfg = st_r.regs[`ADDR_CLK_CONFIG];
	assign shutdown = st_r.regs[`ADDR_CH_SHUTDOWN];
	assign drdy_src = st_r.regs[`ADDR_DRDY_SOURCE];
	assign sync_src = st_r.regs[`ADDR_SYNC_SOURCE];
	assign loop_en = st_r.regs[`ADDR_LOOP_ENABLE];
	assign running = st_r.regs[`ADDR_MAIN_CONFIG][`MAIN_START_BIT];
	assign sync_is_input = sync_src[`SYNC_INPUT_BIT];

	// ****************************************
	// Decimation per channel
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ch
			assign ch_on[gi] = !(shutdown[gi] || shutdown[gi+3]);
			decim_chain u_decim (
				.mclk_i(mclk_i),
				.srst_i(srst_i),
				.tick_i(st_r.tick),
				.run_i(running && ch_on[gi]),
				.realign_i(st_r.realign),
				.stage2_code_i(st_r.regs[`ADDR_STAGE2_DECIM]),
				.stage3_code_i(st_r.regs[`ADDR_STAGE3_DECIM1 + gi]),
				.strobe_o(strobe[gi]),
				.count_o(count[gi])
			);
		end
	endgenerate

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic mapped(input logic [6:0] a);
		case (a)
			`ADDR_MAIN_CONFIG, `ADDR_CH1_ROUTE, `ADDR_CH2_ROUTE,
			`ADDR_CH3_ROUTE, `ADDR_CMD_ENABLE, `ADDR_LEG_DRIVE_ROUTE,
			`ADDR_BUF1_ROUTE, `ADDR_BUF2_ROUTE, `ADDR_BUF3_ROUTE,
			`ADDR_CLK_CONFIG, `ADDR_CH_SHUTDOWN, `ADDR_STAGE2_DECIM,
			`ADDR_STAGE3_DECIM1, `ADDR_STAGE3_DECIM1 + 7'h01, `ADDR_STAGE3_DECIM3,
			`ADDR_DRDY_SOURCE, `ADDR_SYNC_SOURCE,
			`ADDR_LOOP_ENABLE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction : mapped

	// Next enabled loop channel after cur, wrapping
	function automatic logic [1:0] loop_next(input logic [1:0] cur,
		input logic [2:0] en);
		logic [1:0] n;
		n = cur;
		for (int k = 0; k < 3; k++) begin
			n = (n == 2'd2) ? 2'd0 : n + 2'd1;
			if (en[n]) begin
				return n;
			end
		end
		return cur;
	endfunction : loop_next

	// Selected core clock level
	logic core_clk;
	always_comb begin
		if (clk_cfg[`CLK_EXT_SEL_BIT]) begin
			core_clk = clk_in;
		end else begin
			core_clk = xtal && clk_cfg[`CLK_XTAL_EN_BIT];
		end
	end

	// Read data for an address
	logic [2:0] loop_mask;
	assign loop_mask = loop_en[`LOOP_CH1_BIT +: 3];
	function automatic byte_t rd_data(input top_state_s s,
		input logic [6:0] a, input logic run, input byte_t c0,
		input byte_t c1, input byte_t c2);
		byte_t v;
		v = 8'h00;
		if (a == `ADDR_STATUS) begin
			v = {5'h00, s.sync_oe, !s.drdy_n, run};
		end else if (a == `ADDR_LOOP_DATA) begin
			case (s.loop_ch)
				2'd0: v = c0;
				2'd1: v = c1;
				default: v = c2;
			endcase
		end else if (mapped(a)) begin
			v = s.regs[a[5:0]];
		end
		return v;
	endfunction : rd_data

	// ****************************************
	// Next state
	// ****************************************
	logic byte_done;
	byte_t rx_byte;
	logic [6:0] rw_addr;
	logic cs_fall;

	always_comb begin
		st_nxt = st_r;
		rx_byte = {st_r.shin[6:0], sdi};
		byte_done = 1'b0;
		rw_addr = st_r.addr;
		cs_fall = st_r.cs_q && !cs_n;
		st_nxt.sclk_q = sclk;
		st_nxt.cs_q = cs_n;
		st_nxt.clk_q = core_clk;
		st_nxt.sync_q = sync_in_n;

		// Core tick on rising edge of the selected clock
		st_nxt.tick = core_clk && !st_r.clk_q;

		// Clock pin forwarding
		st_nxt.clk_out = xtal;
		st_nxt.clk_oe = clk_cfg[`CLK_PIN_EN_BIT] && !clk_cfg[`CLK_EXT_SEL_BIT];

		// Serial port
		if (cs_n) begin
			st_nxt.phase = SPI_CMD;
			st_nxt.bitc = 3'd0;
			st_nxt.sdo_oe = 1'b0;
			st_nxt.sdo = 1'b0;
		end else if (cs_fall) begin
			st_nxt.phase = SPI_CMD;
			st_nxt.bitc = 3'd0;
		end else if (sclk && !st_r.sclk_q) begin
			st_nxt.shin = rx_byte;
			st_nxt.bitc = st_r.bitc + 3'd1;
			byte_done = (st_r.bitc == 3'd7);
		end else if (!sclk && st_r.sclk_q && st_r.phase == SPI_DATA) begin
			st_nxt.sdo = st_r.shout[7];
			st_nxt.shout = {st_r.shout[6:0], 1'b0};
			st_nxt.sdo_oe = st_r.rd;
		end

		if (byte_done) begin
			case (st_r.phase)
				SPI_CMD: begin
					st_nxt.rd = rx_byte[`SPI_READ_BIT];
					st_nxt.addr = rx_byte[6:0];
					rw_addr = rx_byte[6:0];
					st_nxt.phase = SPI_DATA;
				end
				SPI_DATA: begin
					if (!st_r.rd && mapped(st_r.addr)) begin
						st_nxt.regs[st_r.addr[5:0]] = rx_byte;
					end
					if (st_r.addr != `ADDR_LOOP_DATA) begin
						rw_addr = st_r.addr + 7'h01;
					end
					st_nxt.addr = rw_addr;
				end
				default: st_nxt.phase = SPI_CMD;
			endcase
			if (rx_byte[`SPI_READ_BIT] || st_r.rd) begin
				st_nxt.shout = rd_data(st_r, rw_addr, running,
					count[0], count[1], count[2]);
				if (rw_addr == `ADDR_LOOP_DATA && st_r.phase == SPI_DATA) begin
					st_nxt.loop_ch = loop_next(st_r.loop_ch, loop_mask);
				end
			end
		end
		if (cs_fall) begin
			st_nxt.loop_ch = loop_next(2'd2, loop_mask);
		end

		// Channel power flop tracks the shutdown register
		st_nxt.power = ~(st_nxt.regs[`ADDR_CH_SHUTDOWN][2:0]
			| st_nxt.regs[`ADDR_CH_SHUTDOWN][5:3]);

		// Data-ready pin: set by source channel, released by next frame
		if (cs_fall) begin
			st_nxt.drdy_n = 1'b1;
		end
		if (|(strobe & drdy_src[`SRC_CH1_BIT +: 3])) begin
			st_nxt.drdy_n = 1'b0;
		end

		// Sync pin driven by master, realign from pin on slave
		st_nxt.sync_oe = !sync_is_input && |sync_src[`SRC_CH1_BIT +: 3];
		st_nxt.realign = 1'b0;
		if (st_r.sync_cnt != 8'h00) begin
			st_nxt.sync_cnt = st_r.sync_cnt - 8'h01;
		end
		if (st_nxt.sync_oe && |(strobe & sync_src[`SRC_CH1_BIT +: 3])) begin
			st_nxt.sync_cnt = 8'(`SYNC_PULSE_CYC);
		end
		st_nxt.sync_out_n = (st_nxt.sync_cnt == 8'h00);
		if (sync_is_input && running && st_r.sync_q && !sync_in_n) begin
			st_nxt.realign = 1'b1;
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st_r <= '0;
			st_r.regs <= {`REG_SPACE{`REG_RESET}};
			st_r.phase <= SPI_CMD;
			st_r.sclk_q <= 1'b0;
			// Edge detectors start at the synchroniser's reset level
			st_r.cs_q <= 1'b0;
			st_r.sync_q <= 1'b0;
			st_r.power <= 3'h7;
			st_r.drdy_n <= 1'b1;
			st_r.sync_out_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign sdo_o = st_r.sdo;
	assign sdo_oe_o = st_r.sdo_oe;
	assign clk_pin_o = st_r.clk_out;
	assign clk_pin_oe_o = st_r.clk_oe;
	assign sync_pulse_pin_n_o = st_r.sync_out_n;
	assign sync_pulse_pin_n_oe_o = st_r.sync_oe;
	assign sample_ready_pin_n_o = st_r.drdy_n;
	assign ch1_positive_channel_input_o = st_r.regs[`ADDR_CH1_ROUTE][5:3];
	assign ch1_negative_channel_input_o = st_r.regs[`ADDR_CH1_ROUTE][2:0];
	assign ch2_positive_channel_input_o = st_r.regs[`ADDR_CH2_ROUTE][5:3];
	assign ch2_negative_channel_input_o = st_r.regs[`ADDR_CH2_ROUTE][2:0];
	assign ch3_positive_channel_input_o = st_r.regs[`ADDR_CH3_ROUTE][5:3];
	assign ch3_negative_channel_input_o = st_r.regs[`ADDR_CH3_ROUTE][2:0];
	assign cmd_enable_o = st_r.regs[`ADDR_CMD_ENABLE][2:0];
	assign right_leg_drive_route_o = st_r.regs[`ADDR_LEG_DRIVE_ROUTE][3:0];
	assign buf1_route_o = st_r.regs[`ADDR_BUF1_ROUTE][2:0];
	assign buf2_route_o = st_r.regs[`ADDR_BUF2_ROUTE][2:0];
	assign buf3_route_o = st_r.regs[`ADDR_BUF3_ROUTE][2:0];
	assign channel_power_o = st_r.power;
endmodule : multidev_sync

/* File: multidev_sync_properties.sv */
/*
 * Port-level checker of the multi-chip setup core.
 * Assumes the 250 MHz core clock and the synchronous reset of the core.
 */
`timescale 1ns/1ps
module multidev_sync_properties (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Watched pins
	input wire logic chip_select_n_i,
	input wire logic crystal_pin_a_i,
	input wire logic sdo_oe_o,
	input wire logic clk_pin_o,
	input wire logic clk_pin_oe_o,
	input wire logic sync_pulse_pin_n_o,
	input wire logic sync_pulse_pin_n_oe_o,
	input wire logic sample_ready_pin_n_o,
	input wire logic [2:0] ch1_positive_channel_input_o,
	input wire logic [2:0] channel_power_o
);
	// ****************************************
	// Sync low counter and properties
	// ****************************************
	logic [7:0] low_cnt_r;
	logic [7:0] low_cnt_nxt;
	always_comb begin
		low_cnt_nxt = sync_pulse_pin_n_o ? 8'h00 : low_cnt_r + 8'h01;
	end
	always_ff @(posedge mclk_i) begin
		low_cnt_r <= srst_i ? 8'h00 : low_cnt_nxt;
	end
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);
	reset_vals_a: assert property ($fell(srst_i) |-> sample_ready_pin_n_o && sync_pulse_pin_n_o
		&& !sdo_oe_o && !clk_pin_oe_o && channel_power_o == 3'h7) else $error("reset values wrong");
	sync_width_a: assert property ($rose(sync_pulse_pin_n_o) && sync_pulse_pin_n_oe_o
		|-> low_cnt_r == 8'h7D) else $error("sync pulse width wrong");
	sync_max_a: assert property (sync_pulse_pin_n_oe_o |-> low_cnt_r <= 8'h7D)
		else $error("sync pulse too long");
	clk_follow_a: assert property ($rose(clk_pin_o) && !$past(srst_i, 4) |-> crystal_pin_a_i
		&& $past(crystal_pin_a_i, 2)) else $error("forwarded clock not following crystal");
	sdo_release_a: assert property (chip_select_n_i [*6] |-> !sdo_oe_o)
		else $error("serial out driven while deselected");
	ready_release_a: assert property ($fell(chip_select_n_i) |-> ##[1:8] sample_ready_pin_n_o)
		else $error("data ready not released");
	ready_hold_a: assert property ((chip_select_n_i [*6] ##0 !sample_ready_pin_n_o)
		|=> !sample_ready_pin_n_o) else $error("data ready dropped early");
	cfg_write_a: assert property (($changed(channel_power_o) || $changed(clk_pin_oe_o)
		|| $changed(sync_pulse_pin_n_oe_o) || $changed(ch1_positive_channel_input_o))
		|-> !$past(chip_select_n_i, 2)) else $error("setting changed outside a frame");
	cover property ($rose(sync_pulse_pin_n_o) && sync_pulse_pin_n_oe_o);
	cover property ($fell(sample_ready_pin_n_o));
	cover property ($rose(sdo_oe_o));
endmodule : multidev_sync_properties
bind multidev_sync multidev_sync_properties chk_u (
	.mclk_i(mclk_i), .srst_i(srst_i), .chip_select_n_i(chip_select_n_i),
	.crystal_pin_a_i(crystal_pin_a_i), .sdo_oe_o(sdo_oe_o), .clk_pin_o(clk_pin_o),
	.clk_pin_oe_o(clk_pin_oe_o), .sync_pulse_pin_n_o(sync_pulse_pin_n_o),
	.sync_pulse_pin_n_oe_o(sync_pulse_pin_n_oe_o), .sample_ready_pin_n_o(sample_ready_pin_n_o),
	.ch1_positive_channel_input_o(ch1_positive_channel_input_o),
	.channel_power_o(channel_power_o)
);

/* File: peer_model.sv */
/*
 * Peer front end: crystal, clock forwarded by a master, master sync pulses.
 * Assumes a pull-up on the shared sync line in the bench.
 */
`timescale 1ns/1ps
module peer_model (
	// Requests
	input wire logic clk_en_i,
	input wire logic sync_req_i,
	// Pins
	output logic crystal_o,
	output logic ext_clk_o,
	output logic ext_clk_oe_o,
	output logic sync_n_o,
	output logic sync_oe_o
);
	// ****************************************
	// Clocks and sync pulse
	// ****************************************
	initial begin
		crystal_o = 1'b0;
		ext_clk_o = 1'b0;
		sync_n_o = 1'b1;
		sync_oe_o = 1'b0;
	end
	always #20 crystal_o = ~crystal_o;
	always #20 if (clk_en_i) ext_clk_o = ~ext_clk_o;
	assign ext_clk_oe_o = clk_en_i;
	// Low pulse, then line left to the pull-up
	always @(posedge sync_req_i) begin
		sync_oe_o = 1'b1;
		sync_n_o = 1'b0;
		#500 sync_n_o = 1'b1;
		sync_oe_o = 1'b0;
	end
endmodule : peer_model

/* File: tb_top.sv */
/*
 * Self-checking bench of the multi-chip setup core, master then slave role.
 * Assumes peer_model and the bound checker.
 */
`timescale 1ns/1ps
module tb_top;
	import multidev_pkg::*;
	// ****************************************
	// Stimulus, pins and checks
	// ****************************************
	localparam byte_t M_A [15] = '{8'h01, 8'h02, 8'h0A, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h12,
		8'h14, 8'h21, 8'h22, 8'h23, 8'h27, 8'h28, 8'h2F};
	localparam byte_t M_D [15] = '{8'h11, 8'h19, 8'h07, 8'h04, 8'h01, 8'h02, 8'h03, 8'h05,
		8'h24, 8'h02, 8'h02, 8'h02, 8'h08, 8'h08, 8'h30};
	localparam byte_t S_A [11] = '{8'h01, 8'h02, 8'h03, 8'h12, 8'h21, 8'h22, 8'h23, 8'h24,
		8'h27, 8'h28, 8'h2F};
	localparam byte_t S_D [11] = '{8'h0C, 8'h14, 8'h1C, 8'h06, 8'h02, 8'h02, 8'h02, 8'h02,
		8'h00, 8'h40, 8'h70};
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic cs_n = 1'b1, sclk = 1'b0, sdi = 1'b0, clk_en = 1'b0, sync_req = 1'b0, idle_t = 1'b0;
	logic sdo, sdo_oe, xtal, clk_o, clk_oe, pclk, pclk_oe, sync_o, sync_oe, psync, psync_oe;
	logic rdy_n;
	logic [2:0] p1, n1, p2, n2, p3, n3, cmd, b1, b2, b3, pwr;
	logic [3:0] leg_drv;
	int n_fail = 0;
	int n_tests = 0;
	// Floating clock pin toggles; sync line has a pull-up
	wire clk_w = clk_oe ? clk_o : (pclk_oe ? pclk : idle_t);
	wire sync_w = sync_oe ? sync_o : (psync_oe ? psync : 1'b1);
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) idle_t <= ~idle_t;
	peer_model peer_u (.clk_en_i(clk_en), .sync_req_i(sync_req), .crystal_o(xtal),
		.ext_clk_o(pclk), .ext_clk_oe_o(pclk_oe), .sync_n_o(psync), .sync_oe_o(psync_oe));
	multidev_sync dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .chip_select_n_i(cs_n),
		.sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .crystal_pin_a_i(xtal),
		.clk_pin_i(clk_w), .clk_pin_o(clk_o), .clk_pin_oe_o(clk_oe), .sync_pulse_pin_n_i(sync_w),
		.sync_pulse_pin_n_o(sync_o), .sync_pulse_pin_n_oe_o(sync_oe),
		.sample_ready_pin_n_o(rdy_n), .ch1_positive_channel_input_o(p1),
		.ch1_negative_channel_input_o(n1), .ch2_positive_channel_input_o(p2),
		.ch2_negative_channel_input_o(n2), .ch3_positive_channel_input_o(p3),
		.ch3_negative_channel_input_o(n3), .cmd_enable_o(cmd), .right_leg_drive_route_o(leg_drv),
		.buf1_route_o(b1), .buf2_route_o(b2), .buf3_route_o(b3), .channel_power_o(pwr));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic xfer(input byte_t tx, output byte_t rx);
		for (int i = 7; i >= 0; i--) begin
			sdi <= tx[i];
			repeat (6) @(posedge mclk_i);
			sclk <= 1'b1;
			rx[i] = sdo;
			repeat (6) @(posedge mclk_i);
			sclk <= 1'b0;
		end
	endtask : xfer
	task automatic frame(input byte_t a, input byte_t d, output byte_t rx);
		byte_t junk;
		cs_n <= 1'b0;
		repeat (6) @(posedge mclk_i);
		xfer(a, junk);
		xfer(d, rx);
		repeat (6) @(posedge mclk_i);
		cs_n <= 1'b1;
		repeat (6) @(posedge mclk_i);
	endtask : frame
	task automatic wr(input byte_t a, input byte_t d);
		byte_t r;
		frame(a, d, r);
	endtask : wr
	task automatic rd(input byte_t a, input byte_t e, input string n);
		byte_t r;
		frame(a | 8'h80, 8'h00, r);
		chk(n, {8'h00, e}, {8'h00, r});
	endtask : rd
	task automatic wait_sync(input logic v, inout int c);
		while (sync_w !== v && c < 4000) begin
			@(posedge mclk_i);
			c++;
		end
	endtask : wait_sync
	task automatic t_defaults;
		foreach (M_A[i]) rd(M_A[i], 8'h00, "default");
		chk("power default", {13'h0, pwr}, 16'h0007);
		wr(8'h05, 8'hA5);
		rd(8'h05, 8'h00, "unmapped");
	endtask : t_defaults
	task automatic t_master;
		foreach (M_A[i]) wr(M_A[i], M_D[i]);
		foreach (M_A[i]) rd(M_A[i], M_D[i], "master reg");
		chk("ch1 route", {10'h0, p1, n1}, 16'h0011);
		chk("ch2 route", {10'h0, p2, n2}, 16'h0019);
		chk("cm detect", {13'h0, cmd}, 16'h0007);
		chk("leg drive route", {12'h0, leg_drv}, 16'h0004);
		chk("buffers", {7'h0, b1, b2, b3}, 16'h0053);
		chk("power", {13'h0, pwr}, 16'h0003);
		chk("clk drive", {15'h0, clk_oe}, 16'h0001);
		chk("sync drive", {15'h0, sync_oe}, 16'h0001);
	endtask : t_master
	task automatic t_run;
		int c;
		wr(8'h00, 8'h01);
		c = 0;
		wait_sync(1'b0, c);
		chk("ready with sync", {15'h0, rdy_n}, 16'h0000);
		c = 0;
		wait_sync(1'b1, c);
		wait_sync(1'b0, c);
		chk("sample period", c[15:0], 16'h04B0);
		rd(8'h31, 8'h05, "status");
		chk("ready released", {15'h0, rdy_n}, 16'h0001);
	endtask : t_run
	task automatic t_slave;
		int lows;
		srst_i <= 1'b1;
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		clk_en <= 1'b1;
		foreach (S_A[i]) wr(S_A[i], S_D[i]);
		foreach (S_A[i]) rd(S_A[i], S_D[i], "slave reg");
		chk("slave ch3 route", {10'h0, p3, n3}, 16'h001C);
		chk("slave ch1 ch2 route", {4'h0, p1, n1, p2, n2}, 16'h0314);
		chk("slave clk drive", {15'h0, clk_oe}, 16'h0000);
		chk("slave sync drive", {15'h0, sync_oe}, 16'h0000);
		wr(8'h00, 8'h01);
		lows = 0;
		for (int k = 0; k < 3600; k++) begin
			sync_req <= (k % 600 == 0) && (k < 2400);
			lows += (rdy_n !== 1'b1);
			@(posedge mclk_i);
		end
		rd(8'h50, 8'h01, "realigned count");
		chk("slave ready", lows[15:0], 16'h0000);
	endtask : t_slave
	task automatic complete_run;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (5) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		t_defaults();
		t_master();
		t_run();
		t_slave();
		complete_run();
	end
	initial begin
		#300000;
		n_fail++;
		complete_run();
	end
endmodule : tb_top
